// >>> ssat_channel.sv
// one channel: first trip capture of the shared count
module ssat_channel
    import ssat_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic clk, // clock
    input wire logic rst, // async reset, high
    input wire logic ce, // clock enable
    input wire logic start, // sync pulse ended, new window
    input wire logic win_end, // window closes, publish result
    input wire logic trip, // comparator output
    input wire logic [W-1:0] count, // shared counter value
    input wire logic acquiring, // input still being sampled
    output logic [W-1:0] result_r // published result
);
    logic [W-1:0] cap_r;
    logic done_r;
    logic take;
    assign take = trip && !done_r && !start;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_r <= '0;
            done_r <= 1'b0;
            result_r <= '0;
        end else if (ce) begin
            if (start) begin
                cap_r <= '0; // no crossing leaves zero
                done_r <= 1'b0;
            end else if (take) begin
                cap_r <= count;
                done_r <= 1'b1;
            end
            if (win_end) begin
                // invalid mark while acquiring
                result_r <= acquiring ? (cap_r | {{(W-1){1'b0}}, 1'b1})
                                      : cap_r;
            end
        end
    end
    a_first_trip_held: assert property (
        @(posedge clk) disable iff (rst)
        (ce && done_r && !start) |=> $stable(cap_r))
        else $error("capture changed after first trip");
    a_start_clear: assert property (
        @(posedge clk) disable iff (rst)
        (ce && start) |=> (cap_r == '0 && !done_r))
        else $error("capture not cleared at window start");
    a_invalid_mark: assert property (
        @(posedge clk) disable iff (rst)
        (ce && win_end && acquiring) |=> result_r[0])
        else $error("invalid mark missing");
endmodule : ssat_channel

// >>> ssat_far_end.sv
// far side model: sync pulse generator and the four comparators
module ssat_far_end
    import ssat_pkg::*;
(
    input wire logic clk, // core clock
    output logic sync, // sync pulse, high discharges the ramp
    output logic [2:0] main_trip, // main channel comparators
    output logic aux_trip // aux channel comparator
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sync = 1'b0;
        main_trip = 3'h0;
        aux_trip = 1'b0;
    end
    // comparator i trips at cycle k[i] (0 means never) and again 3 later
    task automatic window(input int k[4], input int len);
        logic [3:0] t;
        @(negedge clk);
        sync = 1'b1;
        repeat (2) @(negedge clk); // held long enough to discharge
        sync = 1'b0;
        for (int c = 1; c <= len; c++) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) begin
                t[i] = (c == k[i] || c == k[i] + 3) && k[i] != 0;
            end
            main_trip = t[2:0];
            aux_trip = t[3];
        end
        @(negedge clk);
        sync = 1'b1;
        main_trip = 3'h0;
        aux_trip = 1'b0;
    endtask : window
endmodule : ssat_far_end

// >>> ssat_pkg.sv
// package: constants for the single slope converter timer
package ssat_pkg;
    localparam int CNT_W = 12;
    localparam logic [11:0] CNT_MAX = 12'hFFF;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam int NUM_CH = 4;
    localparam int AUX_SEL_W = 3;
    localparam int TRIM_W = 3;
    localparam logic [2:0] TRIM_RST = 3'h0;
    localparam logic [2:0] AUX_REF_CODE = 3'h3;
    // mode control register field positions
    localparam int MODE_W = 16;
    localparam int MODE_RATE_BIT = 7;
    localparam int MODE_AUX2_BIT = 5;
    localparam int MODE_AUX1_BIT = 1;
    localparam int MODE_AUX0_BIT = 0;
    localparam int CLK_HZ = 25000000;
    localparam int CLK_PERIOD_NS = 40;
endpackage : ssat_pkg

// >>> ssat_top.sv
// top: shared counter, channel captures, aux mux and trim
// Functional notes
// - four channels converted together, one counter
// - twelve bit counter, result in ticks
// - comparator trip captures count per channel
// - sync pulse resets ramp, its end restarts
// - rate bit clear half rate, set full
// - count limited to 4095 or window length
// - window is half or whole period
// - three main inputs, fourth via 8-way mux
// - aux code from mode bits 5,1,0
// - code 011 selects internal reference input
// - ramp current trim has eight steps
// - result lsb set while input sampling
// - trim three bits, resets to zero
// - no crossing gives result zero, or one while input sampling
module ssat_top
    import ssat_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic clk, // core clock, 25 MHz
    input wire logic rst, // async reset, high
    input wire logic ce, // clock enable
    input wire logic conversion_sync_pulse, // high discharges ramp
    input wire logic [MODE_W-1:0] mode_control_register, // mode bits
    input wire logic [TRIM_W-1:0] trim_in, // trim value to load
    input wire logic trim_we, // load trim
    input wire logic [2:0] main_trip, // main channel comparators
    input wire logic aux_trip, // aux channel comparator
    input wire logic [NUM_CH-1:0] acquiring, // sampling flags
    output logic ramp_discharge_r, // ramp reset switch
    output logic [AUX_SEL_W-1:0] aux_select_r, // aux mux code
    output logic aux_ref_sel_r, // reference routed to aux
    output logic [TRIM_W-1:0] ramp_current_trim, // current step
    output logic [W-1:0] counter_r, // shared count
    output logic [W-1:0] first_channel_result, // channel 1
    output logic [W-1:0] second_channel_result, // channel 2
    output logic [W-1:0] third_channel_result, // channel 3
    output logic [W-1:0] auxiliary_channel_result // aux channel
);
    // counter width and saturation point are fixed at twelve bits
    if (W != CNT_W) begin : g_bad_width
        $error("counter width must be 12");
    end

    logic sync_d_r;
    logic half_r;
    logic running_r;
    logic start;
    logic win_end;
    logic tick;
    logic timer_rate_select;
    logic [AUX_SEL_W-1:0] aux_code;
    logic [TRIM_W-1:0] trim_r;
    logic [NUM_CH-1:0] trips;
    logic [W-1:0] res [NUM_CH];
    assign timer_rate_select = mode_control_register[MODE_RATE_BIT];
    assign aux_code = {mode_control_register[MODE_AUX2_BIT],
                       mode_control_register[MODE_AUX1_BIT],
                       mode_control_register[MODE_AUX0_BIT]};
    // falling edge ends discharge, rising edge closes window
    // each sync pulse bounds a window, half or full period
    assign start = sync_d_r && !conversion_sync_pulse;
    assign win_end = !sync_d_r && conversion_sync_pulse;
    assign tick = timer_rate_select || half_r;
    assign trips = {aux_trip, main_trip};
    assign ramp_current_trim = trim_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_d_r <= 1'b0;
            half_r <= 1'b0;
            running_r <= 1'b0;
            counter_r <= '0;
            ramp_discharge_r <= 1'b0;
        end else if (ce) begin
            sync_d_r <= conversion_sync_pulse;
            ramp_discharge_r <= conversion_sync_pulse;
            if (start) begin
                counter_r <= '0;
                half_r <= 1'b0;
                running_r <= 1'b1;
            end else if (conversion_sync_pulse) begin
                running_r <= 1'b0;
            end else if (running_r) begin
                half_r <= ~half_r;
                // saturate at 4095
                if (tick && counter_r != CNT_MAX) begin
                    counter_r <= counter_r + 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_select_r <= '0;
            aux_ref_sel_r <= 1'b0;
            trim_r <= TRIM_RST;
        end else if (ce) begin
            aux_select_r <= aux_code;
            aux_ref_sel_r <= (aux_code == AUX_REF_CODE);
            if (trim_we) begin
                trim_r <= trim_in; // eight steps
            end
        end
    end
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        ssat_channel #(.W(W)) u_ch (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .start(start),
            .win_end(win_end),
            .trip(trips[i]),
            .count(counter_r),
            .acquiring(acquiring[i]),
            .result_r(res[i])
        );
    end
    assign first_channel_result = res[0];
    assign second_channel_result = res[1];
    assign third_channel_result = res[2];
    assign auxiliary_channel_result = res[3];

    // counter checks
    a_count_restart: assert property (
        @(posedge clk) disable iff (rst)
        (ce && start) |=> (counter_r == '0))
        else $error("counter did not restart");

    a_count_sat: assert property (
        @(posedge clk) disable iff (rst)
        (ce && counter_r == CNT_MAX && !start) |=> counter_r == CNT_MAX)
        else $error("counter passed max");

    a_count_step: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !start) |=> (counter_r == $past(counter_r)
                            || counter_r == $past(counter_r) + 1'b1))
        else $error("counter jumped by more than one tick");

    a_sync_hold: assert property (
        @(posedge clk) disable iff (rst)
        (ce && conversion_sync_pulse) |=> $stable(counter_r))
        else $error("counter moved while window closed");

    a_run_start: assert property (
        @(posedge clk) disable iff (rst)
        (ce && start) |=> running_r)
        else $error("window did not open after sync pulse");

    a_run_stop: assert property (
        @(posedge clk) disable iff (rst)
        (ce && conversion_sync_pulse) |=> !running_r)
        else $error("window still open during sync pulse");

    // rate checks
    a_half_start: assert property (
        @(posedge clk) disable iff (rst)
        (ce && start) |=> !half_r)
        else $error("half rate phase not cleared at start");

    a_half_toggle: assert property (
        @(posedge clk) disable iff (rst)
        (ce && running_r && !conversion_sync_pulse && !start)
        |=> half_r != $past(half_r))
        else $error("half rate phase did not alternate");

    a_slow_rate: assert property (
        @(posedge clk) disable iff (rst)
        (ce && running_r && !timer_rate_select && !conversion_sync_pulse
         && !start && !half_r) |=> $stable(counter_r))
        else $error("slow rate advanced every cycle");

    a_slow_step: assert property (
        @(posedge clk) disable iff (rst)
        (ce && running_r && !timer_rate_select && !conversion_sync_pulse
         && !start && half_r && counter_r != CNT_MAX)
        |=> counter_r == $past(counter_r) + 1'b1)
        else $error("slow rate missed its tick");

    a_fast_rate: assert property (
        @(posedge clk) disable iff (rst)
        (ce && running_r && timer_rate_select && !conversion_sync_pulse
         && !start && counter_r < CNT_MAX)
        |=> counter_r == $past(counter_r) + 1'b1)
        else $error("fast rate not advancing");

    // aux select and reference routing
    a_ref_select: assert property (
        @(posedge clk) disable iff (rst)
        (ce && aux_code == AUX_REF_CODE) |=> aux_ref_sel_r)
        else $error("reference not routed");

    a_ref_clear: assert property (
        @(posedge clk) disable iff (rst)
        (ce && aux_code != AUX_REF_CODE) |=> !aux_ref_sel_r)
        else $error("reference routed for another code");

    a_aux_code: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> aux_select_r == $past(aux_code))
        else $error("aux select mismatch");

    // ramp discharge switch
    a_discharge: assert property (
        @(posedge clk) disable iff (rst)
        (ce && conversion_sync_pulse) |=> ramp_discharge_r)
        else $error("ramp not discharged");

    a_discharge_off: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !conversion_sync_pulse) |=> !ramp_discharge_r)
        else $error("ramp discharged outside sync pulse");

    // trim setting
    a_trim_hold: assert property (
        @(posedge clk) disable iff (rst)
        (!trim_we) |=> $stable(trim_r))
        else $error("trim changed without load");

    a_trim_load: assert property (
        @(posedge clk) disable iff (rst)
        (ce && trim_we) |=> trim_r == $past(trim_in))
        else $error("trim load not taken");

    // clock enable low freezes the state
    a_freeze: assert property (
        @(posedge clk) disable iff (rst)
        (!ce) |=> ($stable(counter_r) && $stable(half_r)
                   && $stable(aux_select_r)))
        else $error("state moved with clock enable low");

    a_result_hold: assert property (
        @(posedge clk) disable iff (rst)
        !(ce && win_end) |=> ($stable(first_channel_result)
                              && $stable(second_channel_result)
                              && $stable(third_channel_result)
                              && $stable(auxiliary_channel_result)))
        else $error("result changed outside window end");
endmodule : ssat_top

// >>> testbench.sv
// testbench: conversion windows, aux select codes and trim steps
`define CHK(nm, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench
    import ssat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [MODE_W-1:0] mode = 16'h0080;
    logic [2:0] trim_in = 3'h0;
    logic trim_we = 1'b0;
    logic ce = 1'b1;
    logic [3:0] acq = 4'h0;
    logic sync, aux_trip, ramp_dis, aux_ref;
    logic [2:0] main_trip, aux_sel, trim;
    logic [11:0] cnt;
    logic [11:0] res [4];
    int n_errors = 0;
    int comparisons = 0;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    ssat_far_end far (.clk(clk), .sync(sync), .main_trip(main_trip),
        .aux_trip(aux_trip));
    ssat_top uut (.clk(clk), .rst(rst), .ce(ce),
        .conversion_sync_pulse(sync), .mode_control_register(mode),
        .trim_in(trim_in), .trim_we(trim_we), .main_trip(main_trip),
        .aux_trip(aux_trip), .acquiring(acq), .ramp_discharge_r(ramp_dis),
        .aux_select_r(aux_sel), .aux_ref_sel_r(aux_ref),
        .ramp_current_trim(trim), .counter_r(cnt),
        .first_channel_result(res[0]), .second_channel_result(res[1]),
        .third_channel_result(res[2]), .auxiliary_channel_result(res[3]));
    task automatic end_sim();
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic conv(input int k[4], input int len,
        input logic [11:0] e[4]);
        int n;
        n = mode[MODE_RATE_BIT] ? len : len / 2;
        if (n > CNT_MAX) n = CNT_MAX;
        far.window(k, len);
        repeat (2) @(negedge clk);
        `CHK("ramp_discharge", 1'b1, ramp_dis)
        `CHK("counter", n[11:0], cnt)
        for (int i = 0; i < 4; i++) `CHK("result", e[i], res[i])
    endtask : conv
    initial begin
        #(CLK_PERIOD_NS * 20000);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        `CHK("trim", TRIM_RST, trim)
        `CHK("counter", 12'h000, cnt)
        conv('{4, 9, 20, 0}, 30, '{12'h3, 12'h8, 12'h13, 12'h0});
        conv('{2, 30, 7, 15}, 30, '{12'h1, 12'h1D, 12'h6, 12'hE});
        conv('{0, 0, 0, 0}, 40, '{12'h0, 12'h0, 12'h0, 12'h0});
        acq = 4'h5;
        conv('{5, 5, 5, 5}, 20, '{12'h5, 12'h4, 12'h5, 12'h4});
        acq = 4'h0;
        mode = 16'h0000;
        conv('{4, 10, 21, 0}, 30, '{12'h1, 12'h4, 12'hA, 12'h0});
        mode = 16'h0080;
        conv('{4200, 0, 0, 4097}, 4300,
            '{12'hFFF, 12'h0, 12'h0, 12'hFFF});
        for (int c = 0; c < 8; c++) begin
            mode = {8'h00, 1'b1, 1'b0, c[2], 3'h0, c[1:0]};
            repeat (2) @(negedge clk);
            `CHK("aux_select", c[2:0], aux_sel)
            `CHK("aux_ref_sel", (c == 3), aux_ref)
        end
        ce = 1'b0;
        mode = 16'h0080;
        trim_in = 3'h5;
        trim_we = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("aux_select_frozen", 3'h7, aux_sel)
        `CHK("trim_frozen", TRIM_RST, trim)
        trim_we = 1'b0;
        ce = 1'b1;
        @(negedge clk);
        `CHK("aux_select_resumed", 3'h0, aux_sel)
        for (int t = 7; t >= 2; t -= 5) begin
            trim_in = t[2:0];
            trim_we = 1'b1;
            @(negedge clk);
            trim_we = 1'b0;
            @(negedge clk);
            `CHK("trim", t[2:0], trim)
        end
        end_sim();
    end
endmodule : testbench
